// File: hdl/brsp_top.v
// Boot ROM serial port pin control
`timescale 1ns/100ps
`include "brsp_defines.vh"
module brsp_top (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Chip state
	input wire chip_reset_low,
	input wire port_enable,
	input wire power_down,
	input wire suspend,
	input wire two_wire_mode,
	// Transfer request
	input wire xfer_start,
	input wire xfer_last,
	input wire dual_bit,
	input wire clk_mode3,
	input wire [7:0] tx_byte,
	output wire xfer_ready,
	output reg [7:0] rx_byte,
	output reg rx_valid,
	// Two-wire drive from core
	input wire tw_scl_low,
	input wire tw_sda_low,
	output reg tw_sda_in,
	// Status
	output reg [7:0] rom_port_control,
	output reg rate_fast,
	// Pins
	output reg rom_select_low,
	output wire rom_sclk_o,
	output wire rom_sclk_oe_low,
	input wire rom_sclk_i,
	output wire rom_dout_o,
	output wire rom_dout_oe_low,
	output wire rom_dout_pd_en,
	input wire rom_rate_strap,
	input wire rom_serial_in,
	output wire rom_serial_in_pd_en
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SHIFT = 2'd1;
	localparam ST_DONE = 2'd2;
	localparam HALF_SLOW = (`BRSP_SYS_MHZ + 2 * `BRSP_SLOW_MHZ - 1) / (2 * `BRSP_SLOW_MHZ);
	localparam HALF_FAST = (`BRSP_SYS_MHZ + 2 * `BRSP_FAST_MHZ - 1) / (2 * `BRSP_FAST_MHZ);

	reg [1:0] rstn_sync_ff;
	reg [1:0] strap_sync_ff;
	reg [1:0] din_sync_ff;
	reg [1:0] sclk_sync_ff;
	reg in_reset_ff;
	reg [1:0] state_ff;
	reg [7:0] shift_ff;
	reg [7:0] rx_sh_ff;
	reg [3:0] bits_ff;
	reg last_ff;
	reg dual_ff;
	reg mode3_ff;
	wire lead_edge;
	wire trail_edge;
	wire sclk_gen;
	wire chip_rst = !rstn_sync_ff[1];
	wire busy = (state_ff == ST_SHIFT);
	wire [3:0] step = dual_ff ? 4'h2 : 4'h1;
	// Rising serial clock edge, the one the ROM samples on
	wire rise_edge = mode3_ff ? trail_edge : lead_edge;
	// Idle level follows the request until a transfer runs
	wire idle_level = busy ? mode3_ff : clk_mode3;
	reg [1:0] samp_dly_ff;

	// Pin synchronisers
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rstn_sync_ff <= 2'b00;
			strap_sync_ff <= 2'b00;
			din_sync_ff <= 2'b00;
			sclk_sync_ff <= 2'b00;
		end else begin
			rstn_sync_ff <= {rstn_sync_ff[0], chip_reset_low};
			strap_sync_ff <= {strap_sync_ff[0], rom_rate_strap};
			din_sync_ff <= {din_sync_ff[0], rom_serial_in};
			sclk_sync_ff <= {sclk_sync_ff[0], rom_sclk_i};
		end
	end

	// Strap capture on first cycle after release
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_reset_ff <= 1'b1;
			rate_fast <= 1'b0;
			rom_port_control <= `BRSP_CTL_RESET;
		end else if (chip_rst) begin
			in_reset_ff <= 1'b1;
		end else if (in_reset_ff) begin
			in_reset_ff <= 1'b0; // R14
			rate_fast <= strap_sync_ff[1]; // R5
			rom_port_control[`BRSP_CTL_RATE_BIT] <= strap_sync_ff[1]; // R12
		end
	end

	brsp_clkdiv #(
		.HALF_SLOW(HALF_SLOW),
		.HALF_FAST(HALF_FAST)
	) u_clkdiv (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(busy),
		.fast(rate_fast),
		.idle_high(idle_level), // R13
		.sclk(sclk_gen),
		.lead_edge(lead_edge),
		.trail_edge(trail_edge)
	);

	// Rising edge delayed by the data-in synchroniser depth
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			samp_dly_ff <= 2'b00;
		end else begin
			samp_dly_ff <= {samp_dly_ff[0], busy && rise_edge};
		end
	end

	// Transfer engine, sample and shift after each rising edge
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			bits_ff <= 4'h0;
			last_ff <= 1'b0;
			dual_ff <= 1'b0;
			mode3_ff <= 1'b0;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			rom_select_low <= 1'b1;
			tw_sda_in <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			tw_sda_in <= strap_sync_ff[1]; // R10
			if (chip_rst || in_reset_ff || (port_enable && power_down) || !port_enable) begin
				state_ff <= ST_IDLE;
				rom_select_low <= 1'b1; // R2
			end else begin
				case (state_ff)
				ST_IDLE: begin
					if (xfer_start && !two_wire_mode) begin
						shift_ff <= tx_byte;
						bits_ff <= 4'h0;
						last_ff <= xfer_last;
						dual_ff <= dual_bit; // R13
						mode3_ff <= clk_mode3; // R13
						rom_select_low <= 1'b0; // R1
						state_ff <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					// Synced data-in now shows the pin level at the rising edge
					if (samp_dly_ff[1]) begin
						rx_sh_ff <= dual_ff ? {rx_sh_ff[5:0], din_sync_ff[1], 1'b0} :
							{rx_sh_ff[6:0], din_sync_ff[1]}; // R11
						bits_ff <= bits_ff + step;
						shift_ff <= dual_ff ? {shift_ff[5:0], 2'b00} : {shift_ff[6:0], 1'b0};
						if (bits_ff + step >= 4'h8)
							state_ff <= ST_DONE;
					end
				end
				ST_DONE: begin
					rx_byte <= rx_sh_ff;
					rx_valid <= 1'b1;
					if (last_ff)
						rom_select_low <= 1'b1; // R1
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	assign xfer_ready = (state_ff == ST_IDLE) && !chip_rst && !in_reset_ff;

	// Clock pin: low in reset, SCL in two-wire mode
	assign rom_sclk_o = chip_rst ? 1'b0 : (two_wire_mode ? 1'b0 : sclk_gen); // R3 R9
	assign rom_sclk_oe_low = chip_rst ? 1'b0 : (two_wire_mode ? !tw_scl_low : 1'b0); // R3 R9

	// Data-out pin: float in reset, suspend by strap, SDA when two-wire
	assign rom_dout_pd_en = chip_rst | in_reset_ff; // R4 R5
	assign rom_dout_o = two_wire_mode ? 1'b0 : (suspend ? 1'b0 : shift_ff[7]); // R8 R10
	assign rom_dout_oe_low = (chip_rst | in_reset_ff) ? 1'b1 : // R4
		suspend ? rate_fast : // R7 R8
		two_wire_mode ? !tw_sda_low : 1'b0; // R10
	assign rom_serial_in_pd_en = 1'b1; // R11
endmodule

// File: hdl/brsp_defines.vh
// Constants for the boot ROM serial port pin block
// How it works
// R1 - Select pin low selects ROM, else high
// R2 - Port enabled and power-down: select held high
// R3 - Serial clock pin low during chip reset
// R4 - Data-out/strap pin floats, pull-down on, in reset
// R5 - Strap latched at release, then data-out, pull-down off
// R6 - Strap zero gives 30 MHz, one 60 MHz; divider from 125 MHz gives about 20.8 and 31.3 MHz
// R7 - Strap one: data-out floats in suspend
// R8 - Strap zero: data-out driven low in suspend
// R9 - Two-wire mode: clock pin is SCL
// R10 - Two-wire mode: data-out pin is SDA, except in suspend, where R7/R8 apply
// R11 - ROM returns data on data-in, pull-down kept
// R12 - Rate flag readable, control resets to 0x02
// R13 - One/two-bit transfers, clock mode 0 or 3
// R14 - Strap loaded once after reset release
`ifndef BRSP_DEFINES_VH
`define BRSP_DEFINES_VH
`define BRSP_CTL_OFFSET 16'h2400
`define BRSP_CTL_RESET 8'h02
`define BRSP_CTL_RATE_BIT 1
`define BRSP_SYS_MHZ 125
`define BRSP_SLOW_MHZ 30
`define BRSP_FAST_MHZ 60
`define BRSP_RESET_MIN_NS 1000
`endif

// File: hdl/brsp_clkdiv.v
// Serial clock generator with edge strobes
`timescale 1ns/100ps
`include "brsp_defines.vh"
module brsp_clkdiv #(
	parameter HALF_SLOW = 3,
	parameter HALF_FAST = 2
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Control
	input wire run,
	input wire fast,
	input wire idle_high,
	// Outputs
	output wire sclk,
	output wire lead_edge,
	output wire trail_edge
);
	reg [3:0] cnt_ff;
	reg sclk_ff;
	wire [3:0] half = fast ? HALF_FAST[3:0] : HALF_SLOW[3:0]; // R6
	wire wrap = run && (cnt_ff == half - 4'h1);
	// Half-period counter and clock toggle
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_ff <= 4'h0;
			sclk_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff <= 4'h0;
			sclk_ff <= idle_high; // R13
		end else if (wrap) begin
			cnt_ff <= 4'h0;
			sclk_ff <= ~sclk_ff;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	assign sclk = sclk_ff;
	assign lead_edge = wrap && (sclk_ff == idle_high);
	assign trail_edge = wrap && (sclk_ff != idle_high);
endmodule

// File: bench/brsp_top_sva.sv
// Checker on the boot ROM port pins
`timescale 1ns/100ps
module brsp_top_sva (
	// Clock, reset and chip state
	input wire clk_sys,
	input wire rst,
	input wire chip_reset_low,
	input wire port_enable,
	input wire power_down,
	input wire suspend,
	input wire two_wire_mode,
	input wire xfer_start,
	input wire tw_scl_low,
	// Design outputs
	input wire rate_fast,
	input wire rom_select_low,
	input wire rom_sclk_o,
	input wire rom_sclk_oe_low,
	input wire rom_dout_o,
	input wire rom_dout_oe_low,
	input wire rom_dout_pd_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Chip reset released long enough for the strap latch
	sequence s_up; chip_reset_low [*8]; endsequence
	property p_sel; $fell(rom_select_low) |-> $past(xfer_start) || $past(xfer_start, 2); endproperty
	a_sel: assert property (p_sel) else $error("select without request");
	property p_pd; port_enable && power_down ##1 port_enable && power_down |-> rom_select_low; endproperty
	a_pd: assert property (p_pd) else $error("select low in power-down");
	property p_clk; !chip_reset_low [*3] |-> !rom_sclk_o && !rom_sclk_oe_low; endproperty
	a_clk: assert property (p_clk) else $error("clock not low in reset");
	property p_float; !chip_reset_low [*3] |-> rom_dout_oe_low && rom_dout_pd_en; endproperty
	a_float: assert property (p_float) else $error("data-out not floating");
	property p_pdoff; s_up |-> !rom_dout_pd_en; endproperty
	a_pdoff: assert property (p_pdoff) else $error("pull-down still on");
	property p_sus1; s_up ##0 suspend && !two_wire_mode && rate_fast |-> rom_dout_oe_low; endproperty
	a_sus1: assert property (p_sus1) else $error("data-out driven in suspend");
	property p_sus0; s_up ##0 suspend && !two_wire_mode && !rate_fast |-> !rom_dout_o && !rom_dout_oe_low; endproperty
	a_sus0: assert property (p_sus0) else $error("data-out not low in suspend");
	property p_scl; s_up ##0 (two_wire_mode && tw_scl_low) [*2] |-> !rom_sclk_o && !rom_sclk_oe_low; endproperty
	a_scl: assert property (p_scl) else $error("clock pin not pulled low");
	c_xfer: cover property ($fell(rom_select_low));
	c_sus: cover property (s_up ##0 suspend);
	c_tw: cover property (two_wire_mode && tw_scl_low);
endmodule
bind brsp_top brsp_top_sva brsp_top_sva_i (.*);

// File: bench/brsp_rom_model.sv
// Serial ROM model returning one byte on the data-in pin
`timescale 1ns/100ps
module brsp_rom_model #(
	parameter [7:0] READ_DATA = 8'ha5
) (
	// Pins
	input wire rom_select_low,
	input wire rom_sclk_o,
	output wire rom_serial_in
);
	integer bit_idx = 8;
	reg skip_ff = 1'b0;
	// Restart on select; idle-high clock skips its first fall
	always @(negedge rom_select_low) begin
		bit_idx = 0;
		skip_ff = rom_sclk_o;
	end
	// Next bit on each falling clock edge
	always @(negedge rom_sclk_o) begin
		if (skip_ff)
			skip_ff = 1'b0;
		else if (!rom_select_low)
			bit_idx = bit_idx + 1;
	end
	// Deselected or done: inverse of the last bit
	assign rom_serial_in = (rom_select_low || bit_idx > 7) ? ~READ_DATA[0] : READ_DATA[7 - bit_idx];
endmodule

// File: bench/brsp_top_tb.sv
// Testbench for the boot ROM serial port pins
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("Error %0t: mismatch", $time); end end
module brsp_top_tb;
	reg clk_sys, rst, chip_reset_low, port_enable, power_down, suspend, two_wire_mode;
	reg xfer_start, xfer_last, dual_bit, clk_mode3, tw_scl_low, tw_sda_low, strap_up, link_clk;
	reg [7:0] tx_byte;
	wire xfer_ready, rx_valid, tw_sda_in, rate_fast, rom_select_low, rom_sclk_o, rom_sclk_oe_low;
	wire rom_dout_o, rom_dout_oe_low, rom_dout_pd_en, rom_serial_in, rom_serial_in_pd_en;
	wire [7:0] rx_byte, rom_port_control;
	integer fails = 0, num_checks = 0, n;
	// Pin levels fed back; strap resistor holds the floating data-out
	wire rom_sclk_i = rom_sclk_oe_low ? link_clk : rom_sclk_o;
	wire rom_rate_strap = rom_dout_oe_low ? strap_up : rom_dout_o;
	brsp_top brsp_top_i (.*);
	brsp_rom_model brsp_rom_model_i (.*);
	// Clocks
	initial begin clk_sys = 0; forever #4 clk_sys = ~clk_sys; end
	initial begin link_clk = 0; forever #40 link_clk = ~link_clk; end
	// Watchdog
	initial begin #100000; fails++; end_sim; end
	task end_sim;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task t_boot(input reg s);
		chip_reset_low = 0; strap_up = s;
		repeat (4) @(negedge clk_sys);
		`CHK({rom_sclk_o, rom_sclk_oe_low}, 2'b00)
		`CHK({rom_dout_oe_low, rom_dout_pd_en}, 2'b11)
		`CHK(rom_serial_in_pd_en, 1'b1)
		chip_reset_low = 1;
		repeat (8) @(negedge clk_sys);
		`CHK({rate_fast, rom_port_control[1], rom_dout_pd_en}, {s, s, 1'b0})
		suspend = 1; strap_up = ~s;
		repeat (4) @(negedge clk_sys);
		`CHK({rom_dout_oe_low, rom_dout_o | s}, {s, s})
		`CHK(rate_fast, s)
		suspend = 0;
		$display("boot test done");
	endtask
	task t_xfer(input reg m3);
		clk_mode3 = m3; xfer_last = 1;
		for (n = 0; xfer_ready !== 1 && n < 50; n++) @(negedge clk_sys);
		@(negedge clk_sys); xfer_start = 1;
		@(negedge clk_sys); xfer_start = 0;
		@(negedge clk_sys);
		`CHK(rom_select_low, 1'b0)
		for (n = 0; rx_valid !== 1 && n < 200; n++) @(negedge clk_sys);
		`CHK(rx_byte, 8'ha5)
		repeat (2) @(negedge clk_sys);
		`CHK(rom_select_low, 1'b1)
		$display("transfer test done");
	endtask
	task t_pd;
		power_down = 1;
		repeat (2) @(negedge clk_sys); xfer_start = 1;
		@(negedge clk_sys); xfer_start = 0;
		repeat (4) @(negedge clk_sys);
		`CHK(rom_select_low, 1'b1)
		power_down = 0;
		$display("power-down test done");
	endtask
	task t_tw;
		two_wire_mode = 1; tw_scl_low = 1; tw_sda_low = 1;
		repeat (3) @(negedge clk_sys);
		`CHK({rom_sclk_oe_low, rom_sclk_o, rom_dout_oe_low, rom_dout_o}, 4'h0)
		`CHK(tw_sda_in, 1'b0)
		tw_scl_low = 0; tw_sda_low = 0;
		repeat (3) @(negedge clk_sys);
		`CHK({rom_sclk_oe_low, rom_dout_oe_low}, 2'b11)
		`CHK(tw_sda_in, strap_up)
		two_wire_mode = 0;
		$display("two-wire test done");
	endtask
	// Main sequence
	initial begin
		{rst, chip_reset_low, port_enable, power_down, suspend, two_wire_mode} = 6'h20;
		{xfer_start, xfer_last, dual_bit, clk_mode3, tw_scl_low, tw_sda_low, strap_up} = 0;
		tx_byte = 8'h3c; port_enable = 1;
		repeat (2) @(negedge clk_sys); rst = 0;
		t_boot(0); t_xfer(0); t_xfer(1); t_pd; t_tw;
		t_boot(1); t_xfer(0);
		end_sim;
	end
endmodule
